/* kwm_regs.sv */
// AXI4-Lite configuration registers for keyboard, power-event and MIDI devices.
`timescale 1ns/1ps
`include "kwm_map.svh"

// Functional notes
// - Keyboard config bit 7 picks reset pin level: 0 active low, 1 high.
// - Bit 6 set blocks mouse clock and data toward the controller.
// - Mouse data to wake logic is never blocked by mouse isolation.
// - Bit 5 set blocks keyboard clock and data toward the controller.
// - Keyboard data to wake logic is never blocked by keyboard isolation.
// - Bit 4 set makes the mouse interrupt the latched controller interrupt.
// - Keyboard device indices 0xF1 to 0xFF are reserved and read zero.
// - Power-event bit 0 reports slow clock absent; 0 means clock connected.
// - Power-event bit 1 turns wake-on-key off and gates its slow clock.
// - MIDI base low byte holds A7..A1; bit 0 is always zero.
module kwm_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic kbd_reset_req,
	output logic kbd_reset_out_pin,
	input wire kwm_pkg::kwm_ps2_t mouse_line,
	input wire kwm_pkg::kwm_ps2_t kbd_line,
	output kwm_pkg::kwm_ps2_t ctl_mouse_line,
	output kwm_pkg::kwm_ps2_t ctl_kbd_line,
	output logic wake_mouse_data_line,
	output logic wake_kbd_data_line,
	input wire logic ctl_mouse_irq,
	input wire logic ctl_kbd_irq,
	input wire logic mouse_irq_clear,
	input wire logic kbd_irq_clear,
	output logic mouse_irq,
	output logic kbd_irq,
	input wire logic slow_clock_pin,
	output logic key_wake_slow_clk,
	output logic slow_clock_absent,
	output logic key_wake_off,
	input wire logic [11:0] io_addr,
	input wire logic io_strobe,
	output logic midi_port_sel
);

	// ==========================================
	// State registers.
	kwm_pkg::kwm_state_t st_reg;
	kwm_pkg::kwm_state_t st_next;

	// Combined MIDI port base, A11..A1 with A0 forced low.
	logic [11:0] midi_base;

	// Write path helpers.
	logic aw_take;
	logic w_take;
	logic have_aw;
	logic have_w;
	logic [11:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_lane0;
	kwm_pkg::kwm_rd_t rd;

	// ==========================================
	// Read lookup: page selects the logical device, index the register.
	function automatic kwm_pkg::kwm_rd_t read_reg(
		input logic [11:0] addr,
		input kwm_pkg::kwm_state_t s
	);
		kwm_pkg::kwm_rd_t r;
		logic [1:0] page;
		logic [7:0] idx;
		page = addr[11:10];
		idx = addr[9:2];
		r.resp = `KWM_RESP_DECERR;
		r.data = 8'h00;
		unique case (page)
			`KWM_PAGE_KBD: begin
				if (idx == `KWM_IDX_CFG) begin
					r.resp = `KWM_RESP_OKAY;
					r.data = {s.kbd_cfg, 1'b0};
				end else if (idx >= `KWM_IDX_RSV_FIRST) begin
					// Reserved indices answer OKAY with zero data.
					r.resp = `KWM_RESP_OKAY;
					r.data = 8'h00;
				end
			end
			`KWM_PAGE_PWR: begin
				if (idx == `KWM_IDX_CFG) begin
					r.resp = `KWM_RESP_OKAY;
					r.data = {6'h00, s.pwr_cfg};
				end
			end
			`KWM_PAGE_MIDI: begin
				if (idx == `KWM_IDX_BASE_HI) begin
					r.resp = `KWM_RESP_OKAY;
					r.data = {4'h0, s.base_hi};
				end else if (idx == `KWM_IDX_BASE_LO) begin
					r.resp = `KWM_RESP_OKAY;
					r.data = {s.base_lo, 1'b0};
				end
			end
			default: begin
				r.resp = `KWM_RESP_DECERR;
			end
		endcase
		return r;
	endfunction

	// ==========================================
	// Handshake decode and the address and data of the write under way.
	always_comb begin
		aw_take = awvalid & st_reg.awready;
		w_take = wvalid & st_reg.wready;
		have_aw = st_reg.aw_held | aw_take;
		have_w = st_reg.w_held | w_take;
		wr_addr = st_reg.aw_held ? st_reg.aw_addr : awaddr;
		wr_data = st_reg.w_held ? st_reg.w_data : wdata[7:0];
		wr_lane0 = st_reg.w_held ? st_reg.w_lane0 : wstrb[0];
		rd = read_reg(araddr, st_reg);
		midi_base = {st_reg.base_hi, st_reg.base_lo, 1'b0};
	end

	// ==========================================
	// Next-state logic for the whole block.
	always_comb begin
		st_next = st_reg;

		// Write channel: address and data may arrive in either order.
		if (aw_take) begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = awaddr;
		end
		if (w_take) begin
			st_next.w_held = 1'b1;
			st_next.w_data = wdata[7:0];
			st_next.w_lane0 = wstrb[0];
		end
		if (st_reg.bvalid && bready) begin
			st_next.bvalid = 1'b0;
		end
		if (have_aw && have_w && !st_reg.bvalid) begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = `KWM_RESP_DECERR;
			unique case (wr_addr[11:10])
				`KWM_PAGE_KBD: begin
					if (wr_addr[9:2] == `KWM_IDX_CFG) begin
						st_next.bresp = `KWM_RESP_OKAY;
						if (wr_lane0) begin
							st_next.kbd_cfg = wr_data[7:1];
						end
					end else if (wr_addr[9:2] >= `KWM_IDX_RSV_FIRST) begin
						// Reserved index: accepted, nothing stored.
						st_next.bresp = `KWM_RESP_OKAY;
					end
				end
				`KWM_PAGE_PWR: begin
					if (wr_addr[9:2] == `KWM_IDX_CFG) begin
						st_next.bresp = `KWM_RESP_OKAY;
						if (wr_lane0) begin
							st_next.pwr_cfg = wr_data[1:0];
						end
					end
				end
				`KWM_PAGE_MIDI: begin
					if (wr_addr[9:2] == `KWM_IDX_BASE_HI) begin
						st_next.bresp = `KWM_RESP_OKAY;
						if (wr_lane0) begin
							st_next.base_hi = wr_data[3:0];
						end
					end else if (wr_addr[9:2] == `KWM_IDX_BASE_LO) begin
						st_next.bresp = `KWM_RESP_OKAY;
						// Bit 0 is not stored, so a stray one cannot shift the decode.
						if (wr_lane0) begin
							st_next.base_lo = wr_data[7:1];
						end
					end
				end
				default: begin
					st_next.bresp = `KWM_RESP_DECERR;
				end
			endcase
		end
		// One write at a time: no new channel beat while one is held or answered.
		st_next.awready = !st_next.aw_held && !st_next.bvalid;
		st_next.wready = !st_next.w_held && !st_next.bvalid;

		// Read channel: one read at a time, answered the cycle after it is taken.
		if (st_reg.rvalid && rready) begin
			st_next.rvalid = 1'b0;
		end
		if (arvalid && st_reg.arready) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = rd.data;
			st_next.rresp = rd.resp;
		end
		st_next.arready = !st_next.rvalid;

		// Reset pin: asserted level follows the polarity bit.
		st_next.reset_pin = kbd_reset_req ?
			st_reg.kbd_cfg[`KWM_KBD_POL] :
			!st_reg.kbd_cfg[`KWM_KBD_POL];

		// Isolation holds the controller side at the idle-high line level.
		st_next.ctl_mouse = st_reg.kbd_cfg[`KWM_KBD_MISO] ?
			2'b11 : mouse_line;
		st_next.ctl_kbd = st_reg.kbd_cfg[`KWM_KBD_KISO] ?
			2'b11 : kbd_line;

		// Wake logic taps the raw pins, ahead of any isolation.
		st_next.wake_mouse_data = mouse_line.data;
		st_next.wake_kbd_data = kbd_line.data;

		// Interrupt latches: a new request in the clear cycle wins.
		st_next.mouse_latch = ctl_mouse_irq ||
			(st_reg.mouse_latch && !mouse_irq_clear);
		st_next.kbd_latch = ctl_kbd_irq ||
			(st_reg.kbd_latch && !kbd_irq_clear);
		st_next.mouse_irq = st_reg.kbd_cfg[`KWM_KBD_MLATCH] ?
			st_reg.mouse_latch : ctl_mouse_irq;
		st_next.kbd_irq = st_reg.kbd_cfg[`KWM_KBD_KBD_IRQ_LATCH] ?
			st_reg.kbd_latch : ctl_kbd_irq;

		// Slow clock reaches the key-wake logic only when present and enabled.
		st_next.absent = st_reg.pwr_cfg[`KWM_PWR_ABSENT];
		st_next.key_off = st_reg.pwr_cfg[`KWM_PWR_KEYOFF];
		st_next.key_wake_clk = slow_clock_pin &&
			!st_reg.pwr_cfg[`KWM_PWR_KEYOFF] &&
			!st_reg.pwr_cfg[`KWM_PWR_ABSENT];

		// MIDI port occupies two byte addresses, so A0 is not compared.
		st_next.midi_sel = io_strobe &&
			(io_addr[11:1] == midi_base[11:1]);
	end

	// ==========================================
	// State register with synchronous active-low reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.kbd_cfg <= 7'(`KWM_RST_KBD >> 1);
			st_reg.pwr_cfg <= 2'(`KWM_RST_PWR);
			st_reg.base_hi <= 4'(`KWM_RST_BASE_HI);
			st_reg.base_lo <= 7'(`KWM_RST_BASE_LO >> 1);
			// Reset pin idles high: polarity resets to active low.
			st_reg.reset_pin <= 1'b1;
			st_reg.ctl_mouse <= 2'b11;
			st_reg.ctl_kbd <= 2'b11;
			st_reg.wake_mouse_data <= 1'b1;
			st_reg.wake_kbd_data <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================
	// Outputs come straight from the state register.
	assign awready = st_reg.awready;
	assign wready = st_reg.wready;
	assign bvalid = st_reg.bvalid;
	assign bresp = st_reg.bresp;
	assign arready = st_reg.arready;
	assign rvalid = st_reg.rvalid;
	assign rresp = st_reg.rresp;
	assign rdata = {24'h00_0000, st_reg.rdata};
	assign kbd_reset_out_pin = st_reg.reset_pin;
	assign ctl_mouse_line = st_reg.ctl_mouse;
	assign ctl_kbd_line = st_reg.ctl_kbd;
	assign wake_mouse_data_line = st_reg.wake_mouse_data;
	assign wake_kbd_data_line = st_reg.wake_kbd_data;
	assign mouse_irq = st_reg.mouse_irq;
	assign kbd_irq = st_reg.kbd_irq;
	assign key_wake_slow_clk = st_reg.key_wake_clk;
	assign slow_clock_absent = st_reg.absent;
	assign key_wake_off = st_reg.key_off;
	assign midi_port_sel = st_reg.midi_sel;

endmodule

/* kwm_map.svh */
// Register indices, pages, field positions and reset values of the config block.
`ifndef KWM_MAP_SVH
`define KWM_MAP_SVH

// ==========================================
// Addressing: byte address = {page, index, 2'b00}.
`define KWM_ADDR_W 12
`define KWM_PAGE_KBD 2'h0
`define KWM_PAGE_PWR 2'h1
`define KWM_PAGE_MIDI 2'h2
`define KWM_IDX_BASE_HI 8'h60
`define KWM_IDX_BASE_LO 8'h61
`define KWM_IDX_CFG 8'hF0
`define KWM_IDX_RSV_FIRST 8'hF1
`define KWM_IDX_RSV_LAST 8'hFF

// ==========================================
// Reset values.
`define KWM_RST_KBD 8'h00
`define KWM_RST_PWR 8'h00
`define KWM_RST_BASE_HI 8'h03
`define KWM_RST_BASE_LO 8'h30

// ==========================================
// Field positions.
`define KWM_KBD_POL 7
`define KWM_KBD_MISO 6
`define KWM_KBD_KISO 5
`define KWM_KBD_MLATCH 4
`define KWM_KBD_KBD_IRQ_LATCH 3
`define KWM_PWR_ABSENT 0
`define KWM_PWR_KEYOFF 1

// ==========================================
// AXI responses.
`define KWM_RESP_OKAY 2'h0
`define KWM_RESP_DECERR 2'h3

`endif

/* kwm_pkg.sv */
// Types shared by the keyboard, power-event and MIDI configuration block.
package kwm_pkg;

	// ==========================================
	// A two-wire serial line pair: clock and data.
	typedef struct packed {
		logic clk;
		logic data;
	} kwm_ps2_t;

	// Result of a register read lookup.
	typedef struct packed {
		logic [1:0] resp;
		logic [7:0] data;
	} kwm_rd_t;

	// ==========================================
	// Every flip-flop of the block.
	typedef struct packed {
		logic [7:1] kbd_cfg;
		logic [1:0] pwr_cfg;
		logic [3:0] base_hi;
		logic [7:1] base_lo;
		logic mouse_latch;
		logic kbd_latch;
		logic aw_held;
		logic [11:0] aw_addr;
		logic w_held;
		logic [7:0] w_data;
		logic w_lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic reset_pin;
		kwm_ps2_t ctl_mouse;
		kwm_ps2_t ctl_kbd;
		logic wake_mouse_data;
		logic wake_kbd_data;
		logic mouse_irq;
		logic kbd_irq;
		logic key_wake_clk;
		logic absent;
		logic key_off;
		logic midi_sel;
	} kwm_state_t;

endpackage

/* kwm_regs_asserts.sv */
// Concurrent checks on the ports of the keyboard, power-event and MIDI config block.
`timescale 1ns/1ps
module kwm_regs_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire kwm_pkg::kwm_ps2_t mouse_line,
	input wire kwm_pkg::kwm_ps2_t kbd_line,
	input wire kwm_pkg::kwm_ps2_t ctl_mouse_line,
	input wire kwm_pkg::kwm_ps2_t ctl_kbd_line,
	input wire logic wake_mouse_data_line,
	input wire logic wake_kbd_data_line,
	input wire logic slow_clock_pin,
	input wire logic key_wake_slow_clk,
	input wire logic slow_clock_absent,
	input wire logic key_wake_off,
	input wire logic io_strobe,
	input wire logic midi_port_sel
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==========================================
	// Pin paths. The first edge after reset is skipped since outputs hold reset levels.
	wake_mouse_a: assert property ($past(aresetn) |-> wake_mouse_data_line == $past(mouse_line.data))
		else $error("mouse wake data wrong");
	wake_kbd_a: assert property ($past(aresetn) |-> wake_kbd_data_line == $past(kbd_line.data))
		else $error("keyboard wake data wrong");
	mouse_pass_a: assert property (($past(aresetn) && ctl_mouse_line != 2'b11) |-> ctl_mouse_line == $past(mouse_line))
		else $error("mouse controller line wrong");
	kbd_pass_a: assert property (($past(aresetn) && ctl_kbd_line != 2'b11) |-> ctl_kbd_line == $past(kbd_line))
		else $error("keyboard controller line wrong");
	key_clk_gate_a: assert property (key_wake_slow_clk |-> !key_wake_off && !slow_clock_absent && $past(slow_clock_pin))
		else $error("slow clock not gated");
	midi_sel_a: assert property (midi_port_sel |-> $past(io_strobe))
		else $error("port select without strobe");

	// ==========================================
	// Register reads and the write response.
	rsv_zero_a: assert property ((arvalid && arready && araddr[11:10] == 2'h0 && araddr[9:2] > 8'hF0) |=> rvalid && rdata == 32'h0000_0000 && rresp == 2'h0)
		else $error("reserved index not zero");
	low_bit0_a: assert property ((arvalid && arready && araddr == 12'h984) |=> rvalid && !rdata[0])
		else $error("base low bit 0 set");
	pwr_read_a: assert property ((arvalid && arready && araddr == 12'h7C0) |=> rdata == {30'h0000_0000, key_wake_off, slow_clock_absent})
		else $error("power config readback wrong");
	rdata_top_a: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	write_resp_a: assert property ((awvalid && awready && wvalid && wready) |=> bvalid)
		else $error("write response late");

	// Main scenarios reached.
	cover property (ctl_mouse_line == 2'b11 && mouse_line != 2'b11);
	cover property (midi_port_sel);
	cover property (key_wake_slow_clk);
endmodule

bind kwm_regs kwm_regs_chk u_chk (.*);

/* kwm_regs_tb_top.sv */
// Self-checking bench for the keyboard, power-event and MIDI config block.
`timescale 1ns/1ps
module kwm_regs_tb_top;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, kbd_reset_req, io_strobe;
	logic ctl_mouse_irq, ctl_kbd_irq, mouse_irq_clear, kbd_irq_clear, slow_clock_pin;
	logic awready, wready, bvalid, arready, rvalid, kbd_reset_out_pin, midi_port_sel;
	logic wake_mouse_data_line, wake_kbd_data_line, mouse_irq, kbd_irq;
	logic key_wake_slow_clk, slow_clock_absent, key_wake_off;
	logic [11:0] awaddr, araddr, io_addr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	kwm_pkg::kwm_ps2_t mouse_line, kbd_line, ctl_mouse_line, ctl_kbd_line;
	int err_total, compares;

	kwm_regs dut (.*);

	// ==========================================
	// Clock and common tasks.
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task stop_test;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task chk8(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task chk1(input logic g, input logic e);
		chk8({7'h00, g}, {7'h00, e});
	endtask

	// A wait that runs out counts as a mismatch and ends the run.
	task tick(inout int n);
		n++;
		if (n > 50) begin
			err_total++;
			stop_test;
		end
	endtask

	// Outputs lag inputs by one cycle; two edges leave margin.
	task st;
		repeat (2) @(posedge aclk);
		#1;
	endtask

	// The write response is judged at the edge that takes it; mapped and reserved
	// indices answer OKAY unless the caller expects a decode error.
	task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			tick(n);
		end while (!bvalid);
		bready <= 1'b0;
		chk8({6'h00, bresp}, {6'h00, r});
	endtask

	task rc(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			tick(n);
		end while (!rvalid);
		rready <= 1'b0;
		chk8(rdata[7:0], e);
		chk8({6'h00, rresp}, {6'h00, r});
	endtask

	task p_irq;
		@(posedge aclk);
		ctl_mouse_irq <= 1'b1;
		ctl_kbd_irq <= 1'b1;
		@(posedge aclk);
		ctl_mouse_irq <= 1'b0;
		ctl_kbd_irq <= 1'b0;
		st;
	endtask

	task io(input logic [11:0] a, input logic s, input logic e);
		@(posedge aclk);
		io_addr <= a;
		io_strobe <= s;
		st;
		chk1(midi_port_sel, e);
	endtask

	// ==========================================
	// Scenarios.
	task t_reset;
		rc(12'h3C0, 8'h00, 2'h0);
		rc(12'h7C0, 8'h00, 2'h0);
		rc(12'h980, 8'h03, 2'h0);
		rc(12'h984, 8'h30, 2'h0);
		rc(12'h004, 8'h00, 2'h3);
		rc(12'hFC0, 8'h00, 2'h3);
		wr(12'h004, 8'hFF, 2'h3);
		wr(12'hFC0, 8'hFF, 2'h3);
		rc(12'h3C0, 8'h00, 2'h0);
	endtask

	task t_pol;
		chk1(kbd_reset_out_pin, 1'b1);
		@(posedge aclk);
		kbd_reset_req <= 1'b1;
		st;
		chk1(kbd_reset_out_pin, 1'b0);
		wr(12'h3C0, 8'h80);
		st;
		chk1(kbd_reset_out_pin, 1'b1);
		@(posedge aclk);
		kbd_reset_req <= 1'b0;
		st;
		chk1(kbd_reset_out_pin, 1'b0);
		wr(12'h3C0, 8'h00);
	endtask

	task t_iso;
		@(posedge aclk);
		mouse_line <= 2'b01;
		kbd_line <= 2'b10;
		st;
		chk8({6'h00, ctl_mouse_line}, 8'h01);
		chk8({6'h00, ctl_kbd_line}, 8'h02);
		wr(12'h3C0, 8'h60);
		@(posedge aclk);
		mouse_line <= 2'b10;
		kbd_line <= 2'b01;
		st;
		chk8({6'h00, ctl_mouse_line}, 8'h03);
		chk8({6'h00, ctl_kbd_line}, 8'h03);
		chk1(wake_mouse_data_line, 1'b0);
		chk1(wake_kbd_data_line, 1'b1);
		wr(12'h3C0, 8'h00);
	endtask

	// Unlatched pulses vanish; latched ones hold until cleared.
	task t_latch;
		p_irq;
		chk1(mouse_irq, 1'b0);
		wr(12'h3C0, 8'h18);
		p_irq;
		chk1(mouse_irq, 1'b1);
		chk1(kbd_irq, 1'b1);
		@(posedge aclk);
		mouse_irq_clear <= 1'b1;
		kbd_irq_clear <= 1'b1;
		@(posedge aclk);
		mouse_irq_clear <= 1'b0;
		kbd_irq_clear <= 1'b0;
		st;
		chk1(mouse_irq, 1'b0);
		chk1(kbd_irq, 1'b0);
		wr(12'h3C0, 8'h00);
	endtask

	task t_rsv;
		for (int i = 8'hF1; i <= 8'hFF; i++) begin
			wr({2'h0, 8'(i), 2'h0}, 8'hFF);
			rc({2'h0, 8'(i), 2'h0}, 8'h00, 2'h0);
		end
		rc(12'h3C0, 8'h00, 2'h0);
	endtask

	task t_pwr;
		slow_clock_pin <= 1'b1;
		for (int v = 0; v < 4; v++) begin
			wr(12'h7C0, 8'(v));
			st;
			chk1(slow_clock_absent, v[0]);
			chk1(key_wake_off, v[1]);
			chk1(key_wake_slow_clk, v == 0);
			rc(12'h7C0, 8'(v), 2'h0);
		end
	endtask

	task t_midi;
		wr(12'h984, 8'hA4);
		rc(12'h984, 8'hA4, 2'h0);
		wr(12'h980, 8'hF2);
		rc(12'h980, 8'h02, 2'h0);
		io(12'h2A5, 1'b1, 1'b1);
		io(12'h2A6, 1'b1, 1'b0);
		io(12'h3A4, 1'b1, 1'b0);
		io(12'h2A4, 1'b0, 1'b0);
	endtask

	// ==========================================
	// Main sequence: every input set at time zero, reset for three cycles.
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, kbd_reset_req, io_strobe} = '0;
		{ctl_mouse_irq, ctl_kbd_irq, mouse_irq_clear, kbd_irq_clear, slow_clock_pin} = '0;
		{awaddr, araddr, io_addr, wdata} = '0;
		wstrb = 4'hF;
		mouse_line = 2'b11;
		kbd_line = 2'b11;
		err_total = 0;
		compares = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		st;
		t_reset;
		t_pol;
		t_iso;
		t_latch;
		t_rsv;
		t_pwr;
		t_midi;
		stop_test;
	end
endmodule
